// >>> core/ddrct_pkg.sv
// Summary of operation
// - wait two clocks after mode register set
// - wait 75 ns after self refresh exit
// - wait 200 clocks before read after exit
// - never owe more than eight refreshes
// - first write strobe rise one clock later
// - write strobe high and low phases wide
// - strobe fall away from clock edges
// - hold write preamble after command edge
// - strobe driven low by command edge
// - hold strobe low after last edge
// - recovery count rounds both terms up
// - illegal operation forces full reinitialization
// - non-read exit gap may use refresh+1
// - change clock only during self refresh
package ddrct_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int clk_period_ns = 10;
   localparam int mode_set_gap = 2;
   localparam int self_refresh_exit_other_gap_ns = 75;
   localparam int auto_refresh_row_cycle_ns = 75;
   localparam int self_refresh_exit_other_cycles =
      (self_refresh_exit_other_gap_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int refresh_cycles =
      (auto_refresh_row_cycle_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int self_refresh_exit_read_gap = 200;
   localparam int max_owed_refresh = 8;
   // memory clock divider: half period in system clocks
   localparam int mclk_half = 4;
   localparam int mem_clk_period_ns = clk_period_ns * mclk_half * 2;
   localparam int write_recovery_time_ns = 15;
   localparam int precharge_time_ns = 20;
   // in memory clocks: the memory counts it against its own clock
   localparam int autoprecharge_write_recovery_count =
      (write_recovery_time_ns + mem_clk_period_ns - 1) / mem_clk_period_ns +
      (precharge_time_ns + mem_clk_period_ns - 1) / mem_clk_period_ns;
   localparam int burst_beats = 4;
   localparam int cnt_w = 8;
   // ****************************************
   // commands (cs_n ras_n cas_n we_n)
   // ****************************************
   localparam logic [3:0] cmd_nop = 4'h7;
   localparam logic [3:0] cmd_mrs = 4'h0;
   localparam logic [3:0] cmd_ref = 4'h1;
   localparam logic [3:0] cmd_read = 4'h5;
   localparam logic [3:0] cmd_write = 4'h4;
   localparam logic [3:0] cmd_pre = 4'h2;
   typedef enum logic [2:0] {
      req_none_type_v, req_mrs, req_ref, req_read, req_write,
      req_sr_enter, req_sr_exit, req_pre
   } ddrct_req_type;
endpackage

// >>> core/ddrct_gap_timer.sv
`timescale 1ns/1ps
// one down-counter per constraint
module ddrct_gap_timer (
   input wire logic clk, // system clock
   input wire logic sys_rst, // sync reset
   input wire logic ce, // clock enable
   input wire logic load, // start the gap
   input wire logic [7:0] count, // gap in cycles
   output logic busy // gap still running
);
   logic [7:0] cnt_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 8'h00;
      end else if (ce) begin
         if (load) begin
            cnt_q <= count;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
   assign busy = (cnt_q != 8'h00);
endmodule

// >>> core/ddrct_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser
module ddrct_sync (
   input wire logic clk, // system clock
   input wire logic sys_rst, // sync reset
   input wire logic ce, // clock enable
   input wire logic d, // async level
   output logic q // synchronised level
);
   logic meta_q;
   logic sync_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else if (ce) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule

// >>> core/ddrct_host.sv
`timescale 1ns/1ps
// controller side: command sequencing, gap timers, write strobe generation
module ddrct_host (
   input wire logic clk, // system clock 100 MHz
   input wire logic sys_rst, // sync reset, active high
   input wire logic ce, // clock enable
   input wire logic [2:0] req, // request code, ddrct_req_type
   input wire logic req_valid, // request present
   input wire logic refresh_tick, // refresh interval elapsed
   input wire logic illegal_event, // timing violation seen
   input wire logic dqs_in, // strobe pin input
   output logic req_ready, // request taken, high one cycle after acceptance
   output logic mem_ck, // memory clock out
   output logic [3:0] mem_cmd, // cs_n ras_n cas_n we_n
   output logic mem_cke, // memory clock enable
   output logic dqs_out, // strobe drive value
   output logic dqs_oe_n, // strobe output enable, low drives
   output logic read_strobe_seen, // read strobe toggle seen
   output logic [3:0] owed_refresh, // refreshes postponed
   output logic init_needed // reinitialization required
);
   // ****************************************
   // memory clock divider
   // ****************************************
   logic [2:0] div_q;
   logic mck_q;
   wire div_end = (div_q == 3'(ddrct_pkg::mclk_half - 1));
   wire mck_rise = div_end && !mck_q;
   wire mck_fall = div_end && mck_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_q <= 3'h0;
         mck_q <= 1'b0;
      end else if (ce) begin
         div_q <= div_end ? 3'h0 : div_q + 3'h1;
         if (div_end) begin
            mck_q <= !mck_q;
         end
      end
   end
   // ****************************************
   // sequencer
   // ****************************************
   typedef enum logic [2:0] {
      st_idle, st_selfref, st_write, st_post, st_dead
   } ddrct_state_type;
   ddrct_state_type state_q;
   logic [3:0] cmd_q;
   logic cke_q;
   logic [3:0] owed_q;
   logic rdy_q;
   logic dqs_q;
   logic oe_n_q;
   logic [3:0] edge_q;
   logic mrs_busy, xo_busy, xr_busy, dal_busy;
   logic dead_q;
   wire [2:0] rq = req;
   wire issue = ce && mck_fall && req_valid && (state_q == st_idle);
   wire is_mrs = (rq == 3'(ddrct_pkg::req_mrs));
   wire is_ref = (rq == 3'(ddrct_pkg::req_ref));
   wire is_rd = (rq == 3'(ddrct_pkg::req_read));
   wire is_wr = (rq == 3'(ddrct_pkg::req_write));
   wire is_sre = (rq == 3'(ddrct_pkg::req_sr_enter));
   wire is_pre = (rq == 3'(ddrct_pkg::req_pre));
   wire gap_ok = !mrs_busy && !dal_busy && !xo_busy;
   wire rd_ok = !mrs_busy && !dal_busy && !xr_busy;
   wire can = is_rd ? rd_ok : gap_ok;
   wire go = issue && can && !dead_q;
   wire sr_exit_go = ce && mck_fall && req_valid && state_q == st_selfref
      && rq == 3'(ddrct_pkg::req_sr_exit);
   wire ref_go = go && is_ref;
   // owed count cannot pass eight: a tick at the limit forces reinitialization unless a refresh is issued in the same cycle
   wire owe_inc = refresh_tick && ce;
   wire owe_full = (owed_q == 4'(ddrct_pkg::max_owed_refresh));
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         owed_q <= 4'h0;
      end else if (owe_inc && !ref_go && !owe_full) begin
         owed_q <= owed_q + 4'h1;
      end else if (ref_go && !owe_inc && owed_q != 4'h0) begin
         owed_q <= owed_q - 4'h1;
      end
   end
   // violation forces power-down and reinit; sticky until reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dead_q <= 1'b0;
      end else if (ce && (illegal_event || (owe_full && owe_inc
         && !ref_go))) begin
         dead_q <= 1'b1;
      end
   end
   ddrct_gap_timer u_mrs (
      .clk(clk), .sys_rst(sys_rst), .ce(ce),
      .load(go && is_mrs),
      .count(8'(ddrct_pkg::mode_set_gap * ddrct_pkg::mclk_half * 2)),
      .busy(mrs_busy)
   );
   ddrct_gap_timer u_xo (
      .clk(clk), .sys_rst(sys_rst), .ce(ce),
      .load(sr_exit_go),
      .count(8'(ddrct_pkg::refresh_cycles + ddrct_pkg::mclk_half * 2)),
      .busy(xo_busy)
   );
   logic [10:0] xr_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xr_q <= 11'h000;
      end else if (ce) begin
         if (sr_exit_go) begin
            xr_q <= 11'(ddrct_pkg::self_refresh_exit_read_gap *
               ddrct_pkg::mclk_half * 2);
         end else if (xr_q != 11'h000) begin
            xr_q <= xr_q - 11'h001;
         end
      end
   end
   assign xr_busy = (xr_q != 11'h000);
   // recovery starts when the strobe is let go after the postamble
   wire dal_load = ce && (state_q == st_post) && (mck_rise || mck_fall);
   ddrct_gap_timer u_dal (
      .clk(clk), .sys_rst(sys_rst), .ce(ce),
      .load(dal_load),
      .count(8'(ddrct_pkg::autoprecharge_write_recovery_count *
         ddrct_pkg::mclk_half * 2)),
      .busy(dal_busy)
   );
   // read strobe watch: pin passes two flops first
   logic dqs_s, dqs_prev_q, seen_q;
   ddrct_sync u_sync (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .d(dqs_in), .q(dqs_s)
   );
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dqs_prev_q <= 1'b0;
         seen_q <= 1'b0;
      end else if (ce) begin
         dqs_prev_q <= dqs_s;
         seen_q <= dqs_s != dqs_prev_q;
      end
   end
   // command and strobe state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= st_idle;
         cmd_q <= ddrct_pkg::cmd_nop;
         cke_q <= 1'b1;
         rdy_q <= 1'b0;
         dqs_q <= 1'b0;
         oe_n_q <= 1'b1;
         edge_q <= 4'h0;
      end else if (ce) begin
         rdy_q <= go || sr_exit_go;
         if (mck_fall) begin
            cmd_q <= ddrct_pkg::cmd_nop;
         end
         case (state_q)
            st_idle: begin
               if (dead_q) begin
                  state_q <= st_dead;
                  cke_q <= 1'b0;
               end else if (go) begin
                  // command set up half a clock before memory rising edge
                  if (is_mrs) cmd_q <= ddrct_pkg::cmd_mrs;
                  else if (is_ref) cmd_q <= ddrct_pkg::cmd_ref;
                  else if (is_rd) cmd_q <= ddrct_pkg::cmd_read;
                  else if (is_pre) cmd_q <= ddrct_pkg::cmd_pre;
                  else if (is_sre) begin
                     cmd_q <= ddrct_pkg::cmd_ref;
                     cke_q <= 1'b0;
                     state_q <= st_selfref;
                  end else if (is_wr) begin
                     cmd_q <= ddrct_pkg::cmd_write;
                     oe_n_q <= 1'b0;
                     dqs_q <= 1'b0;
                     edge_q <= 4'h0;
                     state_q <= st_write;
                  end
               end
            end
            st_selfref: begin
               if (sr_exit_go) begin
                  cke_q <= 1'b1;
                  state_q <= st_idle;
               end
            end
            st_write: begin
               // strobe toggles on memory clock edges: first rise one
               // clock after command, phases half a clock each
               if (mck_rise || mck_fall) begin
                  if (edge_q != 4'h0 || mck_fall) begin
                     edge_q <= edge_q + 4'h1;
                  end
                  if (edge_q == 4'h1) dqs_q <= 1'b1;
                  else if (edge_q > 4'h1) dqs_q <= !dqs_q;
                  // last edge is a fall, so the postamble starts low
                  if (edge_q == 4'(ddrct_pkg::burst_beats)) begin
                     state_q <= st_post;
                  end
               end
            end
            st_post: begin
               // strobe low for a full half clock, then released
               if (mck_rise || mck_fall) begin
                  oe_n_q <= 1'b1;
                  dqs_q <= 1'b0;
                  state_q <= st_idle;
               end
            end
            default: begin
               cke_q <= 1'b0;
            end
         endcase
      end
   end
   assign req_ready = rdy_q;
   assign mem_ck = mck_q;
   assign mem_cmd = cmd_q;
   assign mem_cke = cke_q;
   assign dqs_out = dqs_q;
   assign dqs_oe_n = oe_n_q;
   assign read_strobe_seen = seen_q;
   assign owed_refresh = owed_q;
   assign init_needed = dead_q;
   // ****************************************
   // checks
   // ****************************************
   // cycles since the last self refresh exit, saturating
   logic [11:0] since_exit_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         since_exit_q <= 12'hfff;
      end else if (ce) begin
         if (sr_exit_go) begin
            since_exit_q <= 12'h000;
         end else if (since_exit_q != 12'hfff) begin
            since_exit_q <= since_exit_q + 12'h001;
         end
      end
   end
   property p_mrs_gap;
      @(posedge clk) disable iff (sys_rst)
      (go && is_mrs) |=> !go [*8] ##1 !go [*7];
   endproperty
   a_mrs_gap: assert property (p_mrs_gap) else $error("mrs gap short");
   property p_owed;
      @(posedge clk) disable iff (sys_rst)
      owed_q <= 4'h8;
   endproperty
   a_owed: assert property (p_owed) else $error("owed over eight");
   property p_exit_read;
      @(posedge clk) disable iff (sys_rst)
      (go && is_rd) |-> since_exit_q >= 12'h63f;
   endproperty
   a_exit_read: assert property (p_exit_read)
      else $error("read too soon");
   property p_exit_other;
      @(posedge clk) disable iff (sys_rst)
      go |-> since_exit_q >= 12'h00f;
   endproperty
   a_exit_other: assert property (p_exit_other)
      else $error("command too soon");
   sequence s_wr_start;
      ce && go && is_wr;
   endsequence
   property p_pre_low;
      @(posedge clk) disable iff (sys_rst)
      s_wr_start |=> !dqs_oe_n && !dqs_out;
   endproperty
   a_pre_low: assert property (p_pre_low)
      else $error("no write preamble");
   property p_first_rise;
      @(posedge clk) disable iff (sys_rst)
      s_wr_start |=> !dqs_out [*8];
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("strobe rose early");
   // strobe must sit low through the whole postamble
   property p_post_low;
      @(posedge clk) disable iff (sys_rst)
      (state_q == st_post) |-> !dqs_oe_n && !dqs_out;
   endproperty
   a_post_low: assert property (p_post_low)
      else $error("postamble not low");
   property p_dal_gap;
      @(posedge clk) disable iff (sys_rst)
      dal_load |=> !go [*8] ##1 !go [*7];
   endproperty
   a_dal_gap: assert property (p_dal_gap)
      else $error("recovery too short");
   property p_dead;
      @(posedge clk) disable iff (sys_rst)
      (ce && illegal_event) |=> dead_q ##1 !go;
   endproperty
   a_dead: assert property (p_dead) else $error("no reinit");
   property p_sr_cke;
      @(posedge clk) disable iff (sys_rst)
      (state_q == st_selfref) |-> !mem_cke;
   endproperty
   a_sr_cke: assert property (p_sr_cke) else $error("cke high in sr");
endmodule

// >>> bench/ddrct_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// memory side of the strobe: read bursts only
// ****************************************
module ddrct_mem_model (
   input wire logic mem_ck, // memory clock from the controller
   input wire logic [3:0] mem_cmd, // cs_n ras_n cas_n we_n
   input wire logic mem_cke, // memory clock enable
   output logic dqs_drv, // strobe value while driving
   output logic dqs_en // high while the memory drives the strobe
);
   initial begin
      dqs_drv = 1'b0;
      dqs_en = 1'b0;
   end
   // commands seen during a burst are dropped, like a busy bus
   always @(posedge mem_ck) begin
      if (mem_cke === 1'b1 && mem_cmd === ddrct_pkg::cmd_read) begin
         dqs_en = 1'b1;
         dqs_drv = 1'b0;
         @(posedge mem_ck);
         repeat (ddrct_pkg::burst_beats) begin
            dqs_drv = ~dqs_drv;
            @(mem_ck);
         end
         dqs_en = 1'b0;
      end
   end
endmodule

// >>> bench/ddr_sdram_command_strobe_timing_tb.sv
`timescale 1ns/1ps
module ddr_sdram_command_strobe_timing_tb;
   logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
   logic ce = 1'b1;
   logic refresh_tick = 1'b0, illegal_event = 1'b0, dqs_last = 1'b0;
   logic [2:0] req = 3'h0;
   logic req_ready, mem_ck, mem_cke, dqs_out, dqs_oe_n, seen, init_needed;
   logic [3:0] mem_cmd, owed_refresh;
   logic m_drv, m_en;
   wire logic dqs_w;
   int n_fail = 0, checked = 0, cyc = 0;
   // released strobe shows the inverse of its last level, not a kind 0
   assign dqs_w = !dqs_oe_n ? dqs_out : (m_en ? m_drv : ~dqs_last);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (!dqs_oe_n || m_en) dqs_last <= dqs_w;
   end
   ddrct_host dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .req(req),
      .req_valid(req_valid), .refresh_tick(refresh_tick),
      .illegal_event(illegal_event), .dqs_in(dqs_w), .req_ready(req_ready),
      .mem_ck(mem_ck), .mem_cmd(mem_cmd), .mem_cke(mem_cke),
      .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .read_strobe_seen(seen),
      .owed_refresh(owed_refresh), .init_needed(init_needed));
   ddrct_mem_model mem_u (.mem_ck(mem_ck), .mem_cmd(mem_cmd),
      .mem_cke(mem_cke), .dqs_drv(m_drv), .dqs_en(m_en));
   // ****************************************
   // compares and bus helpers
   // ****************************************
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d comparisons", n_fail, checked);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic cmp_range(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("unexpected count at %0t: %h vs %h", $time, got, lo);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      tick(1);
      sys_rst = 1'b1;
      tick(6);
      sys_rst = 1'b0;
   endtask
   task automatic pulse(input bit bad);
      tick(1);
      if (bad) illegal_event = 1'b1;
      else refresh_tick = 1'b1;
      tick(1);
      illegal_event = 1'b0;
      refresh_tick = 1'b0;
   endtask
   task automatic issue(input logic [2:0] code, input int bound,
      input bit must, output int c);
      int i;
      tick(1);
      c = -1;
      req = code;
      req_valid = 1'b1;
      for (i = 0; i < bound && c < 0; i++) begin
         tick(1);
         if (req_ready === 1'b1) c = cyc;
      end
      req_valid = 1'b0;
      if (must && c < 0) begin
         n_fail++;
         $display("unexpected timeout at %0t: %h vs %h", $time, 1'b0, 1'b1);
         tally_and_finish();
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_mrs();
      int a, b;
      cmp_val({4'h0, mem_cmd}, 8'h07);
      cmp_val({4'h0, owed_refresh}, 8'h00);
      cmp_val({6'h00, mem_cke, dqs_oe_n}, 8'h03);
      issue(ddrct_pkg::req_mrs, 40, 1'b1, a);
      cmp_val({4'h0, mem_cmd}, {4'h0, ddrct_pkg::cmd_mrs});
      issue(ddrct_pkg::req_pre, 80, 1'b1, b);
      cmp_range(b - a, 16, 99999);
   endtask
   task automatic t_write();
      int c, k, t0, ckc, first, nr, last_e, last_r, wmin, rel, rec;
      logic p_dqs, p_ck;
      rec = ((ddrct_pkg::write_recovery_time_ns + 79) / 80
         + (ddrct_pkg::precharge_time_ns + 79) / 80) * 8;
      issue(ddrct_pkg::req_write, 40, 1'b1, c);
      cmp_val({4'h0, mem_cmd}, {4'h0, ddrct_pkg::cmd_write});
      cmp_val({6'h00, dqs_oe_n, dqs_out}, 8'h00);
      t0 = c - 1;
      ckc = -1;
      first = -1;
      nr = 0;
      wmin = 99;
      rel = -1;
      last_e = 0;
      last_r = 0;
      p_dqs = dqs_out;
      p_ck = mem_ck;
      for (k = c - t0 + 1; k < 90 && rel < 0; k++) begin
         tick(1);
         if (mem_ck && !p_ck) begin
            if (ckc < 0) ckc = k;
            last_r = k;
         end
         if (dqs_out !== p_dqs && !dqs_oe_n) begin
            if (first < 0) first = k;
            else if (k - last_e < wmin) wmin = k - last_e;
            if (dqs_out) nr++;
            else cmp_range(k - last_r, 2, 6);
            last_e = k;
         end
         if (dqs_oe_n === 1'b1) rel = k;
         p_dqs = dqs_out;
         p_ck = mem_ck;
      end
      cmp_range(first - ckc, 6, 10);
      cmp_range(wmin, 3, 99);
      cmp_range(nr, ddrct_pkg::burst_beats / 2, ddrct_pkg::burst_beats / 2);
      cmp_range(rel - last_e, 4, 99);
      issue(ddrct_pkg::req_pre, 80, 1'b1, c);
      cmp_range(c - 1 - (t0 + rel), rec, 99999);
   endtask
   task automatic t_read();
      int c, n;
      n = 0;
      issue(ddrct_pkg::req_read, 80, 1'b1, c);
      repeat (120) begin
         tick(1);
         if (seen === 1'b1) n++;
      end
      cmp_range(n, ddrct_pkg::burst_beats, 99);
   endtask
   task automatic t_self();
      int a, b;
      issue(ddrct_pkg::req_sr_enter, 80, 1'b1, a);
      tick(2);
      cmp_val({7'h00, mem_cke}, 8'h00);
      issue(ddrct_pkg::req_sr_exit, 80, 1'b1, a);
      issue(ddrct_pkg::req_read, 2500, 1'b1, b);
      cmp_range(b - a, 1600, 99999);
      tick(150);
      issue(ddrct_pkg::req_sr_enter, 80, 1'b1, a);
      issue(ddrct_pkg::req_sr_exit, 80, 1'b1, a);
      issue(ddrct_pkg::req_pre, 80, 1'b1, b);
      cmp_range(b - a, 8, 99999);
      cmp_val({7'h00, mem_cke}, 8'h01);
   endtask
   task automatic t_refresh();
      int c;
      do_reset();
      repeat (8) pulse(1'b0);
      cmp_val({3'h0, owed_refresh, init_needed}, 8'h10);
      issue(ddrct_pkg::req_ref, 80, 1'b1, c);
      cmp_val({4'h0, mem_cmd}, {4'h0, ddrct_pkg::cmd_ref});
      tick(1);
      cmp_val({4'h0, owed_refresh}, 8'h07);
      repeat (2) pulse(1'b0);
      tick(1);
      cmp_val({7'h00, init_needed}, 8'h01);
   endtask
   task automatic t_freeze();
      logic ck0;
      ce = 1'b0;
      ck0 = mem_ck;
      repeat (2) pulse(1'b0);
      tick(9);
      cmp_val({6'h00, mem_ck, ck0}, {6'h00, ck0, ck0});
      cmp_val({4'h0, owed_refresh}, 8'h00);
      ce = 1'b1;
   endtask
   task automatic t_illegal();
      int c;
      do_reset();
      pulse(1'b1);
      tick(1);
      cmp_val({7'h00, init_needed}, 8'h01);
      issue(ddrct_pkg::req_pre, 40, 1'b0, c);
      cmp_range(c, -1, -1);
   endtask
   initial begin
      do_reset();
      t_freeze();
      t_mrs();
      t_write();
      t_read();
      t_self();
      t_refresh();
      t_illegal();
      tally_and_finish();
   end
endmodule
